//--- hw/bcb_pkg.sv
package bcb_pkg;

    // ***************************************************************
    // Widths
    // ***************************************************************
    localparam int unsigned PC_W   = 21;
    localparam int unsigned ADDR_W = 12;

    // ***************************************************************
    // Opcode fields and encodings
    // ***************************************************************
    localparam logic [3:0] OPC_CLR_NIB   = 4'h9;   // Bit-clear upper nibble.
    localparam logic [7:0] OPC_BR_CC     = 8'he3;  // Branch if carry clear.
    localparam logic [7:0] OPC_BR_NS     = 8'he6;  // Branch if negative set.
    localparam logic [7:0] OPC_BR_NC     = 8'he7;  // Branch if negative clear.
    localparam int unsigned BIT_SEL_LSB  = 9;      // Bit-select field 11:9.
    localparam int unsigned ACC_BIT_POS  = 8;      // Bank-access bit.

    // ***************************************************************
    // Access bank layout: low half in bank 0, high half in the top bank
    // ***************************************************************
    localparam logic [7:0] ACC_SPLIT     = 8'h80;
    localparam logic [3:0] ACC_LOW_BANK  = 4'h0;
    localparam logic [3:0] ACC_HIGH_BANK = 4'hf;

    // ***************************************************************
    // Instruction phases and reset values
    // ***************************************************************
    localparam logic [1:0] PH_Q1 = 2'h0;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q3 = 2'h2;
    localparam logic [1:0] PH_Q4 = 2'h3;
    localparam logic [1:0] PH_RESET = 2'h0;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;

    // ***************************************************************
    // Kinds of instruction in flight and branch conditions
    // ***************************************************************
    typedef enum logic [1:0] {
        K_NOP = 2'b00,
        K_CLR = 2'b01,
        K_BR  = 2'b10
    } bcb_kind_t;

    typedef enum logic [1:0] {
        C_CARRY_CLEAR = 2'b00,
        C_NEG_SET     = 2'b01,
        C_NEG_CLEAR   = 2'b10
    } bcb_cond_t;

endpackage : bcb_pkg

//--- hw/bcb_qphase.sv
`timescale 1ns/10ps
`default_nettype none

// Free-running four-phase instruction cycle counter.
module bcb_qphase (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    output logic [1:0] phase_q
);
    import bcb_pkg::*;

    logic [1:0] phase_d;

    // Phases advance Q1 to Q4 and wrap.
    always_comb begin
        phase_d = phase_q + 2'h1;
    end

    // Register the phase.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            phase_q <= PH_RESET;
        end else begin
            phase_q <= phase_d;
        end
    end

endmodule : bcb_qphase

`default_nettype wire

//--- hw/bcb_core.sv
`timescale 1ns/10ps
`default_nettype none

module bcb_core (
    input  wire logic                        clk_sys,
    input  wire logic                        reset,
    input  wire logic                        instr_valid,
    input  wire logic [15:0]                 instr_word,
    input  wire logic                        flag_n,
    input  wire logic                        flag_c,
    input  wire logic [bcb_pkg::PC_W-1:0]    pc_in,
    input  wire logic [3:0]                  bank_select_register,
    input  wire logic [7:0]                  rf_rdata,
    output logic [1:0]                       phase_q,
    output logic                             rf_re_q,
    output logic [bcb_pkg::ADDR_W-1:0]       rf_raddr_q,
    output logic                             rf_we_q,
    output logic [bcb_pkg::ADDR_W-1:0]       rf_waddr_q,
    output logic [7:0]                       rf_wdata_q,
    output logic                             pc_load_q,
    output logic [bcb_pkg::PC_W-1:0]         pc_target_q,
    output logic                             busy_q
);
    import bcb_pkg::*;

    // ***************************************************************
    // State
    // ***************************************************************
    bcb_kind_t           kind_q,    kind_d;
    bcb_cond_t           cond_q,    cond_d;
    logic [15:0]         op_q,      op_d;
    logic                taken_q,   taken_d;
    logic [7:0]          rd_q,      rd_d;
    logic                rf_re_d;
    logic [ADDR_W-1:0]   rf_raddr_d;
    logic                rf_we_d;
    logic [ADDR_W-1:0]   rf_waddr_d;
    logic [7:0]          rf_wdata_d;
    logic                pc_load_d;
    logic [PC_W-1:0]     pc_target_d;
    logic                busy_d;
    logic [3:0]          bank;
    logic [7:0]          clr_mask;
    logic [PC_W-1:0]     disp;

    // Phase counter shared by every instruction.
    bcb_qphase u_qphase (
        .clk_sys (clk_sys),
        .reset   (reset),
        .phase_q (phase_q)
    );

    // Bank, bit mask and doubled signed offset of the held opcode.
    always_comb begin
        if (op_q[ACC_BIT_POS]) begin
            bank = bank_select_register;
        end else if (op_q[7:0] < ACC_SPLIT) begin
            bank = ACC_LOW_BANK;
        end else begin
            bank = ACC_HIGH_BANK;
        end
        clr_mask = ~(8'h01 << op_q[BIT_SEL_LSB +: 3]);
        disp = {{(PC_W - 9){op_q[7]}}, op_q[7:0], 1'b0};
    end

    // ***************************************************************
    // Instruction sequencing
    // ***************************************************************

    // Next values, one step per phase; outputs land in the phase after the one named.
    always_comb begin
        kind_d      = kind_q;
        cond_d      = cond_q;
        op_d        = op_q;
        taken_d     = taken_q;
        rd_d        = rd_q;
        rf_re_d     = 1'b0;
        rf_raddr_d  = rf_raddr_q;
        rf_we_d     = 1'b0;
        rf_waddr_d  = rf_waddr_q;
        rf_wdata_d  = rf_wdata_q;
        pc_load_d   = 1'b0;
        pc_target_d = pc_target_q;
        busy_d      = busy_q;
        unique case (phase_q)
            PH_Q1: begin
                kind_d  = K_NOP;
                taken_d = 1'b0;
                // Decode, unless this cycle is the idle after a taken branch.
                if (instr_valid && !busy_q) begin
                    op_d = instr_word;
                    if (instr_word[15:12] == OPC_CLR_NIB) begin
                        kind_d  = K_CLR;
                        rf_re_d = 1'b1;
                        if (instr_word[ACC_BIT_POS]) begin
                            rf_raddr_d = {bank_select_register, instr_word[7:0]};
                        end else if (instr_word[7:0] < ACC_SPLIT) begin
                            rf_raddr_d = {ACC_LOW_BANK, instr_word[7:0]};
                        end else begin
                            rf_raddr_d = {ACC_HIGH_BANK, instr_word[7:0]};
                        end
                    end else if (instr_word[15:8] == OPC_BR_CC) begin
                        kind_d = K_BR;
                        cond_d = C_CARRY_CLEAR;
                    end else if (instr_word[15:8] == OPC_BR_NS) begin
                        kind_d = K_BR;
                        cond_d = C_NEG_SET;
                    end else if (instr_word[15:8] == OPC_BR_NC) begin
                        kind_d = K_BR;
                        cond_d = C_NEG_CLEAR;
                    end
                end
            end
            PH_Q2: begin
                // Read the register, or read the offset and test the flag.
                rd_d = rf_rdata;
                if (kind_q == K_BR) begin
                    unique case (cond_q)
                        C_CARRY_CLEAR: taken_d = !flag_c;
                        C_NEG_SET:     taken_d = flag_n;
                        C_NEG_CLEAR:   taken_d = !flag_n;
                        default:       taken_d = 1'b0;
                    endcase
                end
            end
            PH_Q3: begin
                // Process: clear the bit, or form the branch target.
                if (kind_q == K_CLR) begin
                    rf_we_d    = 1'b1;
                    rf_waddr_d = {bank, op_q[7:0]};
                    rf_wdata_d = rd_q & clr_mask;
                end
                if (kind_q == K_BR && taken_q) begin
                    pc_load_d   = 1'b1;
                    pc_target_d = pc_in + disp;
                end
            end
            PH_Q4: begin
                // Taken branch idles the whole next cycle; else nothing.
                busy_d = (kind_q == K_BR) && taken_q;
            end
        endcase
    end

    // Register every value.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            kind_q      <= K_NOP;
            cond_q      <= C_CARRY_CLEAR;
            op_q        <= 16'h0000;
            taken_q     <= 1'b0;
            rd_q        <= 8'h00;
            rf_re_q     <= 1'b0;
            rf_raddr_q  <= 12'h000;
            rf_we_q     <= 1'b0;
            rf_waddr_q  <= 12'h000;
            rf_wdata_q  <= 8'h00;
            pc_load_q   <= 1'b0;
            pc_target_q <= PC_RESET;
            busy_q      <= 1'b0;
        end else begin
            kind_q      <= kind_d;
            cond_q      <= cond_d;
            op_q        <= op_d;
            taken_q     <= taken_d;
            rd_q        <= rd_d;
            rf_re_q     <= rf_re_d;
            rf_raddr_q  <= rf_raddr_d;
            rf_we_q     <= rf_we_d;
            rf_waddr_q  <= rf_waddr_d;
            rf_wdata_q  <= rf_wdata_d;
            pc_load_q   <= pc_load_d;
            pc_target_q <= pc_target_d;
            busy_q      <= busy_d;
        end
    end

    // ***************************************************************
    // Assertions
    // ***************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_dec(logic [7:0] ub);
        phase_q == PH_Q1 && instr_valid && !busy_q && instr_word[15:8] == ub;
    endsequence

    a_clr_read_q2: assert property (phase_q == PH_Q1 && instr_valid && !busy_q
        && instr_word[15:12] == OPC_CLR_NIB |=> rf_re_q && phase_q == PH_Q2
        && rf_raddr_q[7:0] == $past(instr_word[7:0]))
        else $error("bit clear read not issued in second phase");
    a_bank_access: assert property (rf_re_q && !op_q[ACC_BIT_POS] |->
        rf_raddr_q[11:8] == (op_q[7] ? ACC_HIGH_BANK : ACC_LOW_BANK))
        else $error("access bank not used");
    a_clr_write_q4: assert property (rf_re_q |-> ##2 rf_we_q && phase_q == PH_Q4
        && rf_waddr_q == $past(rf_raddr_q, 2)
        && rf_wdata_q == ($past(rf_rdata, 2) & ~(8'h01 << op_q[11:9])))
        else $error("bit clear write wrong");
    a_carry_clear: assert property (s_dec(OPC_BR_CC) ##1 !flag_c |-> ##2 pc_load_q)
        else $error("carry clear branch not taken");
    a_neg_clear: assert property (s_dec(OPC_BR_NC) ##1 flag_n |-> ##2 !pc_load_q)
        else $error("negative clear branch taken with negative set");
    a_neg_clear_taken: assert property (s_dec(OPC_BR_NC) ##1 !flag_n |-> ##2 pc_load_q)
        else $error("negative clear branch not taken");
    a_neg_set: assert property (s_dec(OPC_BR_NS) ##1 flag_n |-> ##2 pc_load_q)
        else $error("negative set branch not taken");
    a_target_calc: assert property (pc_load_q |-> pc_target_q[0] == $past(pc_in[0])
        && pc_target_q == PC_W'($past(pc_in) + PC_W'(2 * $signed(op_q[7:0]))))
        else $error("branch target wrong");
    a_taken_idle: assert property (pc_load_q |-> phase_q == PH_Q4
        ##1 (busy_q && !rf_re_q && !pc_load_q)[*4] ##1 !busy_q)
        else $error("taken branch idle cycle wrong");
    a_not_taken_short: assert property (s_dec(OPC_BR_CC) ##1 flag_c |-> ##3 !busy_q)
        else $error("untaken branch stalled");

endmodule : bcb_core

`default_nettype wire

//--- hw/bcb_end.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

//--- tb/bcb_rf_model.sv
`timescale 1ns/10ps
`default_nettype none

// Register file behind the decoder: reads are combinational while the strobe is high.
module bcb_rf_model (
    input  wire logic                      clk_sys,
    input  wire logic                      rf_re,
    input  wire logic [bcb_pkg::ADDR_W-1:0] rf_raddr,
    input  wire logic                      rf_we,
    input  wire logic [bcb_pkg::ADDR_W-1:0] rf_waddr,
    input  wire logic [7:0]                rf_wdata,
    output logic      [7:0]                rf_rdata
);
    import bcb_pkg::*;
    logic [7:0] mem [4096];
    logic [7:0] last_q;

    // Each location starts as its own low address byte.
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = i[7:0];
        end
        last_q = 8'h00;
    end

    // Writes land on the edge that ends the write phase.
    always @(posedge clk_sys) begin
        if (rf_we) begin
            mem[rf_waddr] <= rf_wdata;
        end
        if (rf_re) begin
            last_q <= mem[rf_raddr];
        end
    end

    // Outside a read the bus shows the inverse of the last value, so a late sample is caught.
    assign rf_rdata = rf_re ? mem[rf_raddr] : ~last_q;
endmodule : bcb_rf_model

`default_nettype wire

//--- tb/test_bit_clear_and_cond_branch.sv
`timescale 1ns/10ps
`default_nettype none

module test_bit_clear_and_cond_branch;
    import bcb_pkg::*;
    logic            clk_sys = 1'b0;
    logic            reset, instr_valid, flag_n, flag_c;
    logic [15:0]     instr_word;
    logic [PC_W-1:0] pc_in, pc_target_q;
    logic [3:0]      bank_select_register;
    logic [7:0]      rf_rdata, rf_wdata_q;
    logic [1:0]      phase_q;
    logic            rf_re_q, rf_we_q, pc_load_q, busy_q;
    logic [11:0]     rf_raddr_q, rf_waddr_q;
    int              failures = 0;
    int              check_count = 0;
    logic [21:0]     notes [$];
    logic [7:0]      shadow [4096];
    logic [21:0]     n;

    always #10 clk_sys = ~clk_sys;

    bcb_core i_dut (.clk_sys(clk_sys), .reset(reset), .instr_valid(instr_valid), .instr_word(instr_word),
        .flag_n(flag_n), .flag_c(flag_c), .pc_in(pc_in), .bank_select_register(bank_select_register),
        .rf_rdata(rf_rdata), .phase_q(phase_q), .rf_re_q(rf_re_q), .rf_raddr_q(rf_raddr_q),
        .rf_we_q(rf_we_q), .rf_waddr_q(rf_waddr_q), .rf_wdata_q(rf_wdata_q), .pc_load_q(pc_load_q),
        .pc_target_q(pc_target_q), .busy_q(busy_q));

    bcb_rf_model i_rf (.clk_sys(clk_sys), .rf_re(rf_re_q), .rf_raddr(rf_raddr_q), .rf_we(rf_we_q),
        .rf_waddr(rf_waddr_q), .rf_wdata(rf_wdata_q), .rf_rdata(rf_rdata));

    // Compares one value and counts it.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        if (failures == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    // Waits for a free decode slot, offering junk opcodes meanwhile that must be ignored.
    task automatic wait_slot();
        for (int k = 0; k < 20; k++) begin
            if (phase_q === PH_Q1 && busy_q === 1'b0) begin
                return;
            end
            instr_word = 16'($urandom);
            @(negedge clk_sys);
        end
        check(32'h0, 32'h1);
        close_out();
    endtask : wait_slot

    // Issues one random instruction and notes what it must produce.
    task automatic issue();
        logic [2:0]  kind;
        logic [7:0]  off;
        logic [2:0]  b;
        logic        a;
        logic        taken;
        logic [11:0] addr;
        wait_slot();
        kind = 3'($urandom % 6);
        instr_valid = (kind != 3'h5);
        off = ($urandom % 4 == 0) ? (($urandom % 2) ? 8'h80 : 8'h7f) : 8'($urandom);
        b = 3'($urandom);
        a = 1'($urandom);
        flag_n = 1'($urandom);
        flag_c = 1'($urandom);
        pc_in = 21'($urandom);
        bank_select_register = 4'($urandom);
        addr = a ? {bank_select_register, off} : {(off < ACC_SPLIT) ? ACC_LOW_BANK : ACC_HIGH_BANK, off};
        taken = (kind == 1 && !flag_c) || (kind == 2 && flag_n) || (kind == 3 && !flag_n);
        case (kind)
            3'h0: instr_word = {OPC_CLR_NIB, b, a, off};
            3'h1: instr_word = {OPC_BR_CC, off};
            3'h2: instr_word = {OPC_BR_NS, off};
            3'h3: instr_word = {OPC_BR_NC, off};
            3'h5: instr_word = {OPC_CLR_NIB, b, a, off};
            default: instr_word = {4'h5, 12'($urandom)};
        endcase
        if (kind == 3'h0) begin
            shadow[addr][b] = 1'b0;
            notes.push_back({2'b00, addr, shadow[addr]});
        end
        if (taken) begin
            notes.push_back({1'b1, pc_in + {{12{off[7]}}, off, 1'b0}});
        end
        @(negedge clk_sys);
        check({31'h0, rf_re_q}, {31'h0, kind == 3'h0});
        if (kind == 3'h0) check({20'h0, rf_raddr_q}, {20'h0, addr});
        repeat (3) @(negedge clk_sys);
        check({31'h0, busy_q}, {31'h0, taken});
    endtask : issue

    // Takes the oldest note whenever a write or a counter load appears.
    always @(negedge clk_sys) begin
        if (!reset) begin
            if (rf_re_q) check({30'h0, phase_q}, {30'h0, PH_Q2});
            if (rf_we_q || pc_load_q) begin
                check({30'h0, phase_q}, {30'h0, PH_Q4});
                n = (notes.size() > 0) ? notes.pop_front() : 22'hx;
            end
            if (rf_we_q) check({2'b00, rf_waddr_q, rf_wdata_q}, n);
            if (pc_load_q) check({1'b1, pc_target_q}, n);
        end
    end

    // Main sequence.
    initial begin
        void'($urandom(18));
        reset = 1'b1;
        instr_valid = 1'b0;
        instr_word = 16'h0000;
        flag_n = 1'b0;
        flag_c = 1'b0;
        pc_in = 21'h000000;
        bank_select_register = 4'h0;
        for (int i = 0; i < 4096; i++) begin
            shadow[i] = i[7:0];
        end
        repeat (12) @(posedge clk_sys);
        // A first run from power-up, then a second one after a reset once the first has drained.
        for (int r = 0; r < 2; r++) begin
            @(negedge clk_sys);
            check({26'h0, busy_q, pc_load_q, rf_we_q, rf_re_q, phase_q}, 32'h0);
            reset = 1'b0;
            repeat (4) @(negedge clk_sys);
            repeat ((r == 0) ? 400 : 40) issue();
            instr_valid = 1'b0; // The last opcode must not be decoded again while draining.
            repeat (12) @(negedge clk_sys);
            check(32'(notes.size()), 32'h0);
            reset = 1'b1;
        end
        close_out();
    end
endmodule : test_bit_clear_and_cond_branch

`default_nettype wire
